// ---- src/gpev_map.svh ----
// register map, field positions and reset values of the pin event port
// Summary of operation
// [RULE_01] disabled pin is never driven as general i/o; alternate function owns it
// [RULE_02] enabled pin is general i/o, high impedance until made an output
// [RULE_03] straps caught at reset pick general or alternate; then enable chooses
// [RULE_04] direction bit: 0 input, 1 output; ignored while pin disabled
// [RULE_05] after reset every direction bit is clear, all pins inputs
// [RULE_06] level bit of enabled input reads the latched pin level
// [RULE_07] enabled output pin drives the level bit's value
// [RULE_08] rising flag sets on low-to-high change of enabled input
// [RULE_09] falling flag sets on high-to-low change of enabled input
// [RULE_10] flags of an output pin hold their value, nothing new recorded
// [RULE_11] writing 1 clears a flag, writing 0 leaves it
// [RULE_12] rise mask gates rise flag or true level into combined event
// [RULE_13] fall mask gates fall flag or inverted level into combined event
// [RULE_14] control bit 5 makes output pin zero drive the combined signal
// [RULE_15] control bit 4 picks event zero: pass-through or combined signal
// [RULE_16] control bit 2 inverts the sense of the combined signal
// [RULE_17] control bit 1 combines terms by or (0) or and (1)
// [RULE_18] control bit 0 picks term source: flags (0) or levels (1)
// [RULE_19] polarity bits 7:4 and 0 pick rising (0) or falling (1) edge event
// [RULE_20] software clears control bit 4 before using pin zero pass-through events
// [RULE_21] all sixteen events go to transfer controller; 0 and 7:4 to processor
// [RULE_22] only delta-or, delta-and, value-and; value-or is reserved
// [RULE_23] pass-through event of an output pin is held off
// [RULE_24] pin inputs pass two flip-flops before sampling and edge detection
`ifndef GPEV_MAP_SVH
`define GPEV_MAP_SVH
`define GPEV_ADR_ENABLE    32'h01b00000
`define GPEV_ADR_DIRECTION 32'h01b00004
`define GPEV_ADR_LEVEL     32'h01b00008
`define GPEV_ADR_RESERVED  32'h01b0000c
`define GPEV_ADR_RISE      32'h01b00010
`define GPEV_ADR_RISE_MASK 32'h01b00014
`define GPEV_ADR_FALL      32'h01b00018
`define GPEV_ADR_FALL_MASK 32'h01b0001c
`define GPEV_ADR_CONTROL   32'h01b00020
`define GPEV_ADR_POLARITY  32'h01b00024
`define GPEV_PINS_RST      16'h0000
`define GPEV_CTRL_RST      6'h00
`define GPEV_CTRL_WMASK    6'h37
`define GPEV_POL_RST       8'h00
`define GPEV_POL_WMASK     8'hf1
`define GPEV_CTRL_DV       0
`define GPEV_CTRL_AND      1
`define GPEV_CTRL_INV      2
`define GPEV_CTRL_EV0SRC   4
`define GPEV_CTRL_PIN0SEL  5
`endif

// ---- src/gpev_pkg.sv ----
// types shared by the pin event port
package gpev_pkg;
    typedef logic [15:0] gpev_pins_t;
    typedef logic [5:0]  gpev_ctrl_t;
    typedef logic [7:0]  gpev_pol_t;
endpackage : gpev_pkg

// ---- src/gpev_top.sv ----
// sixteen-pin general i/o port with edge flags and event logic on classic wishbone
//
// Added by the designer: the Wishbone interface to the registers.
`include "gpev_map.svh"
module gpev_top (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire gpev_pkg::gpev_pins_t strap_gpio_i,
    input  wire gpev_pkg::gpev_pins_t io_pin_i,
    output gpev_pkg::gpev_pins_t   io_pin_o,
    output gpev_pkg::gpev_pins_t   io_pin_oe_o,
    input  wire gpev_pkg::gpev_pins_t alt_dat_i,
    input  wire gpev_pkg::gpev_pins_t alt_oe_i,
    output gpev_pkg::gpev_pins_t   alt_sel_o,
    output gpev_pkg::gpev_pins_t   per_pin_event_o,
    output logic      [4:0]        cpu_event_o,
    output logic                   combined_event_signal_o
);
    gpev_pkg::gpev_pins_t pin_enable_reg;
    gpev_pkg::gpev_pins_t pin_direction_reg;
    gpev_pkg::gpev_pins_t pin_level_reg;
    gpev_pkg::gpev_pins_t rise_flags_reg;
    gpev_pkg::gpev_pins_t fall_flags_reg;
    gpev_pkg::gpev_pins_t rise_term_mask_reg;
    gpev_pkg::gpev_pins_t fall_term_mask_reg;
    gpev_pkg::gpev_ctrl_t event_global_control_reg;
    gpev_pkg::gpev_pol_t  passthru_edge_select_reg;
    gpev_pkg::gpev_pins_t strap_s1;
    gpev_pkg::gpev_pins_t strap_gpio;
    gpev_pkg::gpev_pins_t sync_s1;
    gpev_pkg::gpev_pins_t sync_s2;
    gpev_pkg::gpev_pins_t sync_prev;
    gpev_pkg::gpev_pins_t owned;
    gpev_pkg::gpev_pins_t is_in;
    gpev_pkg::gpev_pins_t is_out;
    gpev_pkg::gpev_pins_t rise_edge;
    gpev_pkg::gpev_pins_t fall_edge;
    gpev_pkg::gpev_pins_t falling_sel;
    gpev_pkg::gpev_pins_t next_event;
    gpev_pkg::gpev_pins_t term_hi;
    gpev_pkg::gpev_pins_t term_lo;
    gpev_pkg::gpev_pins_t wmask;
    gpev_pkg::gpev_pins_t level_view;
    logic                 req;
    logic                 wr;
    logic                 comb_raw;
    logic                 combined;
    logic                 next_combined;
    logic [31:0]          next_rdata;

    // bus handshake: ack one cycle after request, dropped the cycle after
    assign req = wb_cyc_i & wb_stb_i;
    assign wr  = req & wb_we_i & wb_ack_o;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= next_rdata;
        end
    end

    // straps caught while reset is held, after two stages
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            strap_s1 <= strap_gpio_i;
            if (rst_i) begin
                strap_gpio <= strap_s1; // RULE_03
            end
        end
    end

    // pin input synchroniser and previous sample for edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_s1   <= `GPEV_PINS_RST;
            sync_s2   <= `GPEV_PINS_RST;
            sync_prev <= `GPEV_PINS_RST;
        end else if (ce_i) begin
            sync_s1   <= io_pin_i;
            sync_s2   <= sync_s1; // RULE_24
            sync_prev <= sync_s2;
        end
    end

    assign owned  = strap_gpio & pin_enable_reg; // RULE_03
    assign is_in  = owned & ~pin_direction_reg; // RULE_04
    assign is_out = owned & pin_direction_reg; // RULE_04
    assign rise_edge = is_in & sync_s2 & ~sync_prev; // RULE_08
    assign fall_edge = is_in & ~sync_s2 & sync_prev; // RULE_09

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_enable_reg           <= `GPEV_PINS_RST;
            pin_direction_reg        <= `GPEV_PINS_RST; // RULE_05
            pin_level_reg            <= `GPEV_PINS_RST;
            rise_term_mask_reg       <= `GPEV_PINS_RST;
            fall_term_mask_reg       <= `GPEV_PINS_RST;
            event_global_control_reg <= `GPEV_CTRL_RST;
            passthru_edge_select_reg <= `GPEV_POL_RST;
        end else if (ce_i && wr) begin
            case (wb_adr_i)
                `GPEV_ADR_ENABLE: begin
                    pin_enable_reg <= (pin_enable_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `GPEV_ADR_DIRECTION: begin
                    pin_direction_reg <= (pin_direction_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `GPEV_ADR_LEVEL: begin
                    pin_level_reg <= (pin_level_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `GPEV_ADR_RISE_MASK: begin
                    rise_term_mask_reg <= (rise_term_mask_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `GPEV_ADR_FALL_MASK: begin
                    fall_term_mask_reg <= (fall_term_mask_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
                end
                `GPEV_ADR_CONTROL: begin
                    if (wb_sel_i[0]) begin
                        event_global_control_reg <= wb_dat_i[5:0] & `GPEV_CTRL_WMASK;
                    end
                end
                `GPEV_ADR_POLARITY: begin
                    if (wb_sel_i[0]) begin
                        passthru_edge_select_reg <= wb_dat_i[7:0] & `GPEV_POL_WMASK;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // edge flags: a new edge wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_flags_reg <= `GPEV_PINS_RST;
            fall_flags_reg <= `GPEV_PINS_RST;
        end else if (ce_i) begin
            rise_flags_reg <= (rise_flags_reg
                & ~((wr && wb_adr_i == `GPEV_ADR_RISE) ? wb_dat_i[15:0] & wmask : `GPEV_PINS_RST)) // RULE_11
                | rise_edge; // RULE_08 RULE_10
            fall_flags_reg <= (fall_flags_reg
                & ~((wr && wb_adr_i == `GPEV_ADR_FALL) ? wb_dat_i[15:0] & wmask : `GPEV_PINS_RST)) // RULE_11
                | fall_edge; // RULE_09 RULE_10
        end
    end

    // logic mode terms and combination
    always_comb begin
        if (event_global_control_reg[`GPEV_CTRL_DV]) begin
            term_hi = sync_s2; // RULE_18
            term_lo = ~sync_s2;
        end else begin
            term_hi = rise_flags_reg; // RULE_18
            term_lo = fall_flags_reg;
        end
        term_hi = term_hi & rise_term_mask_reg & is_in; // RULE_12
        term_lo = term_lo & fall_term_mask_reg & is_in; // RULE_13
        if (event_global_control_reg[`GPEV_CTRL_AND]) begin
            comb_raw = (|((rise_term_mask_reg | fall_term_mask_reg) & is_in))
                & (&(term_hi | ~(rise_term_mask_reg & is_in)))
                & (&(term_lo | ~(fall_term_mask_reg & is_in))); // RULE_17
        end else if (event_global_control_reg[`GPEV_CTRL_DV]) begin
            comb_raw = 1'b0; // RULE_22
        end else begin
            comb_raw = |(term_hi | term_lo); // RULE_17
        end
        next_combined = comb_raw ^ event_global_control_reg[`GPEV_CTRL_INV]; // RULE_16
    end

    // pass-through events: pins with no polarity bit use the rising edge
    assign falling_sel = {8'h00, passthru_edge_select_reg[7:4], 3'h0, passthru_edge_select_reg[0]};

    always_comb begin
        next_event = (rise_edge & ~falling_sel) | (fall_edge & falling_sel); // RULE_19 RULE_23
        if (event_global_control_reg[`GPEV_CTRL_EV0SRC]) begin
            next_event[0] = next_combined; // RULE_15
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            combined        <= 1'b0;
            per_pin_event_o <= `GPEV_PINS_RST;
        end else if (ce_i) begin
            combined        <= next_combined;
            per_pin_event_o <= next_event; // RULE_21
        end
    end

    assign combined_event_signal_o = combined;
    assign cpu_event_o = {per_pin_event_o[7:4], per_pin_event_o[0]}; // RULE_21

    // pin drive
    always_comb begin
        io_pin_o = pin_level_reg; // RULE_07
        if (event_global_control_reg[`GPEV_CTRL_PIN0SEL]) begin
            io_pin_o[0] = combined; // RULE_14
        end
        io_pin_o    = (io_pin_o & owned) | (alt_dat_i & ~owned); // RULE_01
        io_pin_oe_o = is_out | (alt_oe_i & ~owned); // RULE_02
    end

    assign alt_sel_o = ~owned; // RULE_01

    // read path
    assign level_view = (sync_s2 & is_in) | (pin_level_reg & ~is_in); // RULE_06

    always_comb begin
        next_rdata = 32'h00000000;
        case (wb_adr_i)
            `GPEV_ADR_ENABLE:    next_rdata[15:0] = pin_enable_reg;
            `GPEV_ADR_DIRECTION: next_rdata[15:0] = pin_direction_reg;
            `GPEV_ADR_LEVEL:     next_rdata[15:0] = level_view;
            `GPEV_ADR_RISE:      next_rdata[15:0] = rise_flags_reg;
            `GPEV_ADR_RISE_MASK: next_rdata[15:0] = rise_term_mask_reg;
            `GPEV_ADR_FALL:      next_rdata[15:0] = fall_flags_reg;
            `GPEV_ADR_FALL_MASK: next_rdata[15:0] = fall_term_mask_reg;
            `GPEV_ADR_CONTROL:   next_rdata[5:0]  = event_global_control_reg;
            `GPEV_ADR_POLARITY:  next_rdata[7:0]  = passthru_edge_select_reg;
            default:             next_rdata       = 32'h00000000;
        endcase
    end
endmodule : gpev_top

// ---- verif/gpev_board.sv ----
// board-side model: each pin carries the port's drive or the board's own level
module gpev_board (
    input  wire logic [15:0] drv_i,
    input  wire logic [15:0] oe_i,
    input  wire logic [15:0] board_i,
    output logic      [15:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_o = (drv_i & oe_i) | (board_i & ~oe_i);
endmodule : gpev_board

// ---- verif/gpev_top_sva.sv ----
// assertions on the ports of the pin event port
`include "gpev_map.svh"
module gpev_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] strap_gpio_i,
    input wire logic [15:0] io_pin_i,
    input wire logic [15:0] io_pin_o,
    input wire logic [15:0] io_pin_oe_o,
    input wire logic [15:0] alt_dat_i,
    input wire logic [15:0] alt_oe_i,
    input wire logic [15:0] alt_sel_o,
    input wire logic [15:0] per_pin_event_o,
    input wire logic [4:0]  cpu_event_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_latency_a: assert property (req_s |=> ack_s)
        else $error("ack late or held");
    rsvd_zero_a: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i == `GPEV_ADR_RESERVED) |-> wb_dat_o == 32'h0)
        else $error("reserved read not zero");
    alt_drive_a: assert property ((((io_pin_oe_o ^ alt_oe_i) | (io_pin_o ^ alt_dat_i)) & alt_sel_o) == 16'h0)
        else $error("alternate pin not passed through");
    strap_owner_a: assert property ((~alt_sel_o & ~strap_gpio_i) == 16'h0)
        else $error("strapped pin taken as general i/o");
    reset_state_a: assert property ($past(rst_i) |-> alt_sel_o == 16'hffff && io_pin_oe_o == alt_oe_i)
        else $error("pins not released after reset");
    event_map_a: assert property (cpu_event_o == {per_pin_event_o[7:4], per_pin_event_o[0]})
        else $error("processor events misrouted");
    edge_cause_a: assert property ((per_pin_event_o & 16'hfffe & ~($past(io_pin_i, 3) ^ $past(io_pin_i, 4))) == 16'h0)
        else $error("event without synchronised pin change");
    out_quiet_a: assert property ((per_pin_event_o & 16'hfffe & $past(io_pin_oe_o) & ~$past(alt_sel_o)) == 16'h0)
        else $error("event on output pin");
endmodule : gpev_chk
bind gpev_top gpev_chk u_chk (.*);

// ---- verif/testbench.sv ----
// random and corner traffic for the pin event port
`include "gpev_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rd, r, seed = 32'h4bab;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [15:0] strap_gpio_i = 16'h7fff, alt_dat_i = '0, alt_oe_i = '0, board = '0, b, nb;
    logic [15:0] io_pin_i, io_pin_o, io_pin_oe_o, alt_sel_o, per_pin_event_o;
    logic [4:0]  cpu_event_o;
    logic        wb_ack_o, combined_event_signal_o;
    int          n_errors = 0, checked = 0, cycles = 0, e4, e5, ev_cnt [16] = '{default: 0};
    gpev_top dut (.*);
    gpev_board u_board (.drv_i(io_pin_o), .oe_i(io_pin_oe_o), .board_i(board), .pin_o(io_pin_i));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic comb_exp(logic [2:0] c);
        return ((c[1:0] == 2'h1) ? 1'b0 : 1'b1) ^ c[2];
    endfunction : comb_exp
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(logic we, logic [31:0] adr, logic [31:0] dat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : xfer
    always @(posedge clk_i) begin
        cycles++;
        for (int i = 0; i < 16; i++) ev_cnt[i] += per_pin_event_o[i];
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        r = rnd();
        alt_dat_i <= r[15:0];
        alt_oe_i <= r[31:16];
        xfer(1'b0, `GPEV_ADR_DIRECTION, '0); chk(rd, '0);
        xfer(1'b1, `GPEV_ADR_RESERVED, 32'hffffffff);
        xfer(1'b0, `GPEV_ADR_RESERVED, '0); chk(rd, '0);
        xfer(1'b0, 32'h01b00040, '0); chk(rd, '0);
        xfer(1'b1, `GPEV_ADR_ENABLE, 32'hffff);
        xfer(1'b1, `GPEV_ADR_DIRECTION, 32'h00ff);
        r = rnd();
        xfer(1'b1, `GPEV_ADR_LEVEL, {16'h0, r[15:0]});
        board <= 16'(rnd());
        repeat (5) @(posedge clk_i);
        chk(io_pin_oe_o, {alt_oe_i[15], 15'h00ff});
        chk(io_pin_o[7:0], r[7:0]);
        xfer(1'b0, `GPEV_ADR_LEVEL, '0); chk(rd, (board & 16'h7f00) | (r[15:0] & 16'h80ff));
        for (int k = 0; k < 4; k++) begin
            xfer(1'b1, `GPEV_ADR_RISE, 32'hffff);
            xfer(1'b1, `GPEV_ADR_FALL, 32'hffff);
            b = board;
            nb = 16'(rnd());
            board <= nb;
            repeat (5) @(posedge clk_i);
            xfer(1'b0, `GPEV_ADR_RISE, '0); chk(rd, ~b & nb & 16'h7f00);
            xfer(1'b0, `GPEV_ADR_FALL, '0); chk(rd, b & ~nb & 16'h7f00);
            xfer(1'b1, `GPEV_ADR_FALL, 32'h5555);
            xfer(1'b0, `GPEV_ADR_FALL, '0); chk(rd, b & ~nb & 16'h2a00);
        end
        board <= 16'h0000;
        repeat (5) @(posedge clk_i);
        xfer(1'b1, `GPEV_ADR_RISE, 32'hffff);
        xfer(1'b1, `GPEV_ADR_RISE_MASK, 32'h0100);
        board <= 16'h0100;
        repeat (5) @(posedge clk_i);
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, `GPEV_ADR_CONTROL, 32'h30 | c);
            repeat (3) @(posedge clk_i);
            chk(combined_event_signal_o, comb_exp(c));
            chk(cpu_event_o[0], comb_exp(c));
            chk(io_pin_o[0], comb_exp(c));
        end
        xfer(1'b1, `GPEV_ADR_RISE_MASK, '0);
        xfer(1'b1, `GPEV_ADR_FALL_MASK, 32'h0200);
        xfer(1'b1, `GPEV_ADR_CONTROL, 32'h33);
        repeat (3) @(posedge clk_i);
        chk(combined_event_signal_o, 1'b1);
        xfer(1'b1, `GPEV_ADR_CONTROL, 32'h37);
        repeat (3) @(posedge clk_i);
        chk(combined_event_signal_o, 1'b0);
        xfer(1'b1, `GPEV_ADR_CONTROL, '0);
        xfer(1'b1, `GPEV_ADR_POLARITY, 32'h10);
        xfer(1'b1, `GPEV_ADR_DIRECTION, '0);
        repeat (6) @(posedge clk_i);
        e4 = ev_cnt[4];
        e5 = ev_cnt[5];
        board <= 16'h0130;
        repeat (6) @(posedge clk_i);
        board <= 16'h0100;
        repeat (6) @(posedge clk_i);
        chk(ev_cnt[4] - e4, 1);
        chk(ev_cnt[5] - e5, 1);
        wrap_up();
    end
endmodule : testbench
